// File: tdp_pins.sv
// Load on the two compare output pins.
// Assumes a weak pull-down holds an undriven pin low.
`timescale 1ns/1ps
module tdp_pins (
   // Pin drivers
   input  wire logic out_a,
   input  wire logic oe_a,
   input  wire logic out_b,
   input  wire logic oe_b,
   // Pin levels
   output logic      lvl_a,
   output logic      lvl_b
);
   // An undriven pin falls to the pull-down, never keeps the old value
   assign lvl_a = oe_a ? out_a : 1'b0;
   assign lvl_b = oe_b ? out_b : 1'b0;
endmodule : tdp_pins

// File: tdp_pkg.sv
// Constants, types and decode helpers for the 16-bit timer waveform block.
// Assumes a single clock domain; registers sit on an AHB-Lite slave port.
package tdp_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] TDP_ADDR_WAVE_CTRL = 8'h80;  // waveform_output_control
   localparam logic [7:0] TDP_ADDR_CTRL_B    = 8'h84;  // mode bits 4:3, clock select
   localparam logic [7:0] TDP_ADDR_COUNTER   = 8'h88;  // counter_value
   localparam logic [7:0] TDP_ADDR_CMP_A     = 8'h8C;  // compare_a_value
   localparam logic [7:0] TDP_ADDR_CMP_B     = 8'h90;  // compare_b_value
   localparam logic [7:0] TDP_ADDR_CAPTURE   = 8'h94;  // capture_value
   localparam logic [7:0] TDP_ADDR_FLAGS     = 8'h98;  // write one to clear
   localparam logic [7:0] TDP_ADDR_PORT      = 8'h9C;  // direction and port data

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int          TDP_OM_A_LSB     = 6;
   localparam int          TDP_OM_B_LSB     = 4;
   localparam logic [7:0]  TDP_WAVE_CTRL_WM = 8'hF3;  // Bits 3:2 read as zero
   localparam logic [7:0]  TDP_WAVE_CTRL_RST = 8'h00;
   localparam int          TDP_MODE_HI_LSB  = 3;
   localparam int          TDP_FLAG_OVF     = 0;
   localparam int          TDP_FLAG_CMP_A   = 1;
   localparam int          TDP_FLAG_CMP_B   = 2;
   localparam int          TDP_FLAG_CAP     = 3;
   localparam int          TDP_PORT_DIR_LSB = 0;      // Bits 1:0 pin_direction_bit A/B
   localparam int          TDP_PORT_DAT_LSB = 4;      // Bits 5:4 normal port data A/B

   // ************************************************************
   // Counter limits and prescale masks
   // ************************************************************
   localparam logic [15:0] TDP_BOTTOM  = 16'h0000;
   localparam logic [15:0] TDP_MAX     = 16'hFFFF;
   localparam logic [15:0] TDP_TOP_8B  = 16'h00FF;
   localparam logic [15:0] TDP_TOP_9B  = 16'h01FF;
   localparam logic [15:0] TDP_TOP_10B = 16'h03FF;
   localparam logic [9:0]  TDP_DIV8    = 10'h007;
   localparam logic [9:0]  TDP_DIV64   = 10'h03F;
   localparam logic [9:0]  TDP_DIV256  = 10'h0FF;
   localparam logic [9:0]  TDP_DIV1024 = 10'h3FF;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      MC_NORMAL = 3'b000,
      MC_CTC    = 3'b001,
      MC_FAST   = 3'b010,
      MC_PCORR  = 3'b011,
      MC_PFC    = 3'b100
   } tdp_mode_t;

   typedef enum logic [1:0] {
      TS_NONE  = 2'b00,
      TS_FIXED = 2'b01,
      TS_CAPT  = 2'b10,
      TS_CMPA  = 2'b11
   } tdp_top_src_t;

   // Per-tick timing events shared by both compare channels
   typedef struct packed {
      logic      tick;
      logic      up;
      logic      at_top;
      logic      at_bottom;
      tdp_mode_t mode;
   } tdp_evt_t;

   // Mode class from waveform_mode_select
   function automatic tdp_mode_t tdp_mode_class(input logic [3:0] wgm);
      tdp_mode_t m;
      m = MC_NORMAL;
      unique case (wgm)
         4'd1, 4'd2, 4'd3, 4'd10, 4'd11: m = MC_PCORR;
         4'd4, 4'd12:                    m = MC_CTC;
         4'd5, 4'd6, 4'd7, 4'd14, 4'd15: m = MC_FAST;
         4'd8, 4'd9:                     m = MC_PFC;
         default:                        m = MC_NORMAL;
      endcase
      return m;
   endfunction : tdp_mode_class

   // Source of the top value
   function automatic tdp_top_src_t tdp_top_src(input logic [3:0] wgm);
      tdp_top_src_t s;
      s = TS_NONE;
      unique case (wgm)
         4'd1, 4'd2, 4'd3, 4'd5, 4'd6, 4'd7: s = TS_FIXED;
         4'd8, 4'd10, 4'd12, 4'd14:          s = TS_CAPT;
         4'd4, 4'd9, 4'd11, 4'd15:           s = TS_CMPA;
         default:                            s = TS_NONE;
      endcase
      return s;
   endfunction : tdp_top_src

endpackage : tdp_pkg

// File: tdp_timer.sv
// 16-bit timer with dual-slope, fast and non-PWM waveform outputs A and B.
// Assumes an AHB-Lite master on hclk (200 MHz) and port pins outside.
`timescale 1ns/1ps
module tdp_timer
   import tdp_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Compare output pins
   output logic             pin_a_out,
   output logic             pin_a_oe,
   output logic             pin_b_out,
   output logic             pin_b_oe
);

   // ************************************************************
   // State
   // ************************************************************
   logic [7:0]  wave_ctrl_r, wave_ctrl_nxt;
   logic [4:0]  ctrl_b_r, ctrl_b_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic        up_r, up_nxt;
   logic [15:0] cmpa_buf_r, cmpa_buf_nxt, cmpa_r, cmpa_nxt;
   logic [15:0] cmpb_buf_r, cmpb_buf_nxt, cmpb_r, cmpb_nxt;
   logic [15:0] capt_r, capt_nxt;
   logic [3:0]  flags_r, flags_nxt;
   logic [5:0]  port_r, port_nxt;
   logic [9:0]  presc_r, presc_nxt;
   logic        wr_pend_r, wr_pend_nxt;
   logic [7:0]  wr_addr_r, wr_addr_nxt;
   logic [31:0] hrdata_nxt;
   logic        pa_out_nxt, pa_oe_nxt, pb_out_nxt, pb_oe_nxt;

   logic [3:0]   wgm;
   tdp_mode_t    mode;
   tdp_top_src_t tsrc;
   logic [15:0]  top;
   logic         tick;
   logic         at_top, at_bottom, reload;
   logic         match_a, match_b;
   logic [3:0]   fl_set, fl_clr;
   tdp_evt_t     evt;
   logic         wave_a, conn_a, wave_b, conn_b;
   logic         acc, wr_hit;
   logic [31:0]  wdat;

   assign wgm  = {ctrl_b_r[TDP_MODE_HI_LSB +: 2], wave_ctrl_r[1:0]};
   assign mode = tdp_mode_class(wgm);
   assign tsrc = tdp_top_src(wgm);

   // ************************************************************
   // Top selection and timer tick
   // ************************************************************
   // Top value from fixed widths, capture or active compare A
   always_comb begin
      unique case (tsrc)
         TS_CAPT: top = capt_r;
         TS_CMPA: top = cmpa_r;
         TS_FIXED: begin
            unique case (wgm[1:0])
               2'b01:   top = TDP_TOP_8B;
               2'b10:   top = TDP_TOP_9B;
               default: top = TDP_TOP_10B;
            endcase
         end
         default: top = TDP_MAX;
      endcase
   end

   // Prescaler runs free; the tick is an enable, never a clock
   always_comb begin
      presc_nxt = presc_r + 10'h001;
      unique case (ctrl_b_r[2:0])
         3'd1:    tick = 1'b1;
         3'd2:    tick = (presc_r & TDP_DIV8) == TDP_DIV8;
         3'd3:    tick = (presc_r & TDP_DIV64) == TDP_DIV64;
         3'd4:    tick = (presc_r & TDP_DIV256) == TDP_DIV256;
         3'd5:    tick = presc_r == TDP_DIV1024;
         default: tick = 1'b0;                          // Stopped, external not supported
      endcase
   end

   assign at_top    = cnt_r == top;
   assign at_bottom = cnt_r == TDP_BOTTOM;
   assign match_a   = cnt_r == cmpa_r;
   assign match_b   = cnt_r == cmpb_r;

   // Buffer reload point per mode
   always_comb begin
      unique case (mode)
         MC_PCORR: reload = at_top;
         MC_PFC:   reload = at_bottom;
         MC_FAST:  reload = at_top;                     // Counter wraps to bottom next
         default:  reload = 1'b0;
      endcase
   end

   assign evt = '{tick: tick, up: up_r, at_top: at_top,
                  at_bottom: (mode == MC_FAST) ? at_top : at_bottom, mode: mode};

   // ************************************************************
   // Bus decode
   // ************************************************************
   assign acc    = hsel && htrans[1] && hready;
   assign wr_hit = wr_pend_r;
   assign wdat   = hwdata;

   // ************************************************************
   // Counter, compare buffers and flags
   // ************************************************************
   always_comb begin
      cnt_nxt      = cnt_r;
      up_nxt       = up_r;
      cmpa_buf_nxt = cmpa_buf_r;
      cmpb_buf_nxt = cmpb_buf_r;
      cmpa_nxt     = cmpa_r;
      cmpb_nxt     = cmpb_r;
      capt_nxt     = capt_r;
      fl_set       = 4'h0;
      fl_clr       = 4'h0;
      if (tick) begin
         unique case (mode)
            MC_PCORR, MC_PFC: begin
               if (up_r && at_top) begin
                  up_nxt  = 1'b0;
                  cnt_nxt = cnt_r - 16'h0001;
               end else if (!up_r && at_bottom) begin
                  up_nxt  = 1'b1;
                  cnt_nxt = cnt_r + 16'h0001;
               end else begin
                  cnt_nxt = up_r ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
               end
               fl_set[TDP_FLAG_OVF] = at_bottom;
            end
            MC_FAST: begin
               cnt_nxt = at_top ? TDP_BOTTOM : cnt_r + 16'h0001;
               up_nxt  = 1'b1;
               fl_set[TDP_FLAG_OVF] = at_top;
            end
            MC_CTC: begin
               cnt_nxt = at_top ? TDP_BOTTOM : cnt_r + 16'h0001;
               up_nxt  = 1'b1;
               fl_set[TDP_FLAG_OVF] = cnt_r == TDP_MAX;
            end
            default: begin
               cnt_nxt = cnt_r + 16'h0001;
               up_nxt  = 1'b1;
               fl_set[TDP_FLAG_OVF] = cnt_r == TDP_MAX;
            end
         endcase
         if (reload) begin
            cmpa_nxt = cmpa_buf_r;
            cmpb_nxt = cmpb_buf_r;
         end
         // A compare above top never matches, since the count turns back or wraps at top
         fl_set[TDP_FLAG_CMP_A] = match_a || (tsrc == TS_CMPA && at_top);
         fl_set[TDP_FLAG_CMP_B] = match_b;
         fl_set[TDP_FLAG_CAP]   = tsrc == TS_CAPT && at_top;
      end
      // Software writes take the data phase
      if (wr_hit) begin
         unique case (wr_addr_r)
            TDP_ADDR_COUNTER: cnt_nxt = wdat[15:0];
            TDP_ADDR_CAPTURE: capt_nxt = wdat[15:0];
            TDP_ADDR_FLAGS:   fl_clr = wdat[3:0];
            TDP_ADDR_CMP_A: begin
               cmpa_buf_nxt = wdat[15:0];
               if (mode == MC_NORMAL || mode == MC_CTC) cmpa_nxt = wdat[15:0];
            end
            TDP_ADDR_CMP_B: begin
               cmpb_buf_nxt = wdat[15:0];
               if (mode == MC_NORMAL || mode == MC_CTC) cmpb_nxt = wdat[15:0];
            end
            default: ;
         endcase
      end
      // Hardware set wins over a clear in the same cycle
      flags_nxt = (flags_r & ~fl_clr) | fl_set;
   end

   // ************************************************************
   // Control registers and bus slave
   // ************************************************************
   always_comb begin
      wave_ctrl_nxt = wave_ctrl_r;
      ctrl_b_nxt    = ctrl_b_r;
      port_nxt      = port_r;
      if (wr_hit) begin
         unique case (wr_addr_r)
            TDP_ADDR_WAVE_CTRL: wave_ctrl_nxt = wdat[7:0] & TDP_WAVE_CTRL_WM;
            TDP_ADDR_CTRL_B:    ctrl_b_nxt = wdat[4:0];
            TDP_ADDR_PORT:      port_nxt = wdat[5:0];
            default: ;
         endcase
      end
      wr_pend_nxt = acc && hwrite;
      wr_addr_nxt = acc ? haddr[7:0] : wr_addr_r;
      // Read data is fetched in the address phase; unmapped reads give zero
      hrdata_nxt = 32'h0000_0000;
      if (acc && !hwrite && haddr[31:8] == 24'h00_0000) begin
         unique case (haddr[7:0])
            TDP_ADDR_WAVE_CTRL: hrdata_nxt = {24'h00_0000, wave_ctrl_r};
            TDP_ADDR_CTRL_B:    hrdata_nxt = {27'h000_0000, ctrl_b_r};
            TDP_ADDR_COUNTER:   hrdata_nxt = {16'h0000, cnt_r};
            TDP_ADDR_CMP_A:     hrdata_nxt = {16'h0000, cmpa_buf_r};
            TDP_ADDR_CMP_B:     hrdata_nxt = {16'h0000, cmpb_buf_r};
            TDP_ADDR_CAPTURE:   hrdata_nxt = {16'h0000, capt_r};
            TDP_ADDR_FLAGS:     hrdata_nxt = {28'h000_0000, flags_r};
            TDP_ADDR_PORT:      hrdata_nxt = {26'h000_0000, port_r};
            default: ;
         endcase
      end
   end

   // Upper address bits must be zero for a write to land
   logic wr_addr_ok_r;

   // ************************************************************
   // Waveform channels
   // ************************************************************
   tdp_wave_chan u_chan_a (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .evt       (evt),
      .om        (wave_ctrl_r[TDP_OM_A_LSB +: 2]),
      .toggle_ok (wgm == 4'd9 || wgm == 4'd11 || wgm == 4'd14 || wgm == 4'd15 ||
                  mode == MC_NORMAL || mode == MC_CTC),
      .match     (match_a),
      .cmp_zero  (cmpa_r == TDP_BOTTOM),
      .cmp_top   (cmpa_r == top),
      .wave      (wave_a),
      .conn      (conn_a)
   );

   tdp_wave_chan u_chan_b (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .evt       (evt),
      .om        (wave_ctrl_r[TDP_OM_B_LSB +: 2]),
      .toggle_ok (mode == MC_NORMAL || mode == MC_CTC),
      .match     (match_b),
      .cmp_zero  (cmpb_r == TDP_BOTTOM),
      .cmp_top   (cmpb_r == top),
      .wave      (wave_b),
      .conn      (conn_b)
   );

   // ************************************************************
   // Pin drive
   // ************************************************************
   // Waveform replaces port data; the direction bit alone enables the driver
   always_comb begin
      pa_out_nxt = conn_a ? wave_a : port_r[TDP_PORT_DAT_LSB];
      pb_out_nxt = conn_b ? wave_b : port_r[TDP_PORT_DAT_LSB + 1];
      pa_oe_nxt  = port_r[TDP_PORT_DIR_LSB];
      pb_oe_nxt  = port_r[TDP_PORT_DIR_LSB + 1];
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wave_ctrl_r  <= TDP_WAVE_CTRL_RST;
         ctrl_b_r     <= 5'h00;
         cnt_r        <= TDP_BOTTOM;
         up_r         <= 1'b1;
         cmpa_buf_r   <= 16'h0000;
         cmpb_buf_r   <= 16'h0000;
         cmpa_r       <= 16'h0000;
         cmpb_r       <= 16'h0000;
         capt_r       <= 16'h0000;
         flags_r      <= 4'h0;
         port_r       <= 6'h00;
         presc_r      <= 10'h000;
         wr_pend_r    <= 1'b0;
         wr_addr_r    <= 8'h00;
         wr_addr_ok_r <= 1'b0;
         hrdata       <= 32'h0000_0000;
         hreadyout    <= 1'b1;
         hresp        <= 1'b0;
         pin_a_out    <= 1'b0;
         pin_a_oe     <= 1'b0;
         pin_b_out    <= 1'b0;
         pin_b_oe     <= 1'b0;
      end else begin
         wave_ctrl_r  <= wr_addr_ok_r ? wave_ctrl_nxt : wave_ctrl_r;
         ctrl_b_r     <= wr_addr_ok_r ? ctrl_b_nxt : ctrl_b_r;
         cnt_r        <= cnt_nxt;
         up_r         <= up_nxt;
         cmpa_buf_r   <= cmpa_buf_nxt;
         cmpb_buf_r   <= cmpb_buf_nxt;
         cmpa_r       <= cmpa_nxt;
         cmpb_r       <= cmpb_nxt;
         capt_r       <= capt_nxt;
         flags_r      <= flags_nxt;
         port_r       <= wr_addr_ok_r ? port_nxt : port_r;
         presc_r      <= presc_nxt;
         wr_pend_r    <= wr_pend_nxt && haddr[31:8] == 24'h00_0000;
         wr_addr_r    <= wr_addr_nxt;
         wr_addr_ok_r <= wr_pend_nxt && haddr[31:8] == 24'h00_0000;
         hrdata       <= hrdata_nxt;
         hreadyout    <= 1'b1;                          // Zero wait states
         hresp        <= 1'b0;                          // Always OKAY
         pin_a_out    <= pa_out_nxt;
         pin_a_oe     <= pa_oe_nxt;
         pin_b_out    <= pb_out_nxt;
         pin_b_oe     <= pb_oe_nxt;
      end
   end

endmodule : tdp_timer

// File: tdp_timer_bench.sv
// Bench for tdp_timer: bus tasks and pin timing checks.
// Assumes hready is the slave's own hreadyout.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
   $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module tdp_timer_bench;
   import tdp_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, oa, ea, ob, eb, lvl_a, lvl_b;
   logic [31:0] haddr, hwdata, hrdata, r, v;
   logic [1:0]  htrans;
   int          failures, num_checks, hi, lo;
   tdp_timer u_tdp_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .pin_a_out(oa), .pin_a_oe(ea), .pin_b_out(ob), .pin_b_oe(eb));
   tdp_pins u_tdp_pins (.out_a(oa), .oe_a(ea), .out_b(ob), .oe_b(eb), .lvl_a(lvl_a), .lvl_b(lvl_b));
   initial begin hclk = 1'b0; forever #2.5 hclk = ~hclk; end
   task automatic results();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // A used-up bound ends the run as a failure
   task automatic tmo(input int n);
      if (n >= 500) begin failures++; results(); end
   endtask : tmo
   // One single AHB transfer, waiting on hready in both phases
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w; n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 500);
      htrans <= 2'b00; hwdata <= d; tmo(n); n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 500);
      // Select stays up between calls; htrans alone marks a transfer
      q = hrdata; tmo(n);
   endtask : xfer
   task automatic wr(input logic [31:0] a, input logic [31:0] d); xfer(1'b1, a, d, r); endtask : wr
   function automatic logic lv(input logic b); return b ? lvl_b : lvl_a; endfunction : lv
   // High and low times of one full period, in clock cycles
   task automatic meas(input logic b);
      int n;
      n = 0; while (lv(b) !== 1'b0 && n < 500) begin @(posedge hclk); n++; end
      while (lv(b) !== 1'b1 && n < 500) begin @(posedge hclk); n++; end
      tmo(n); hi = 0; lo = 0;
      while (lv(b) === 1'b1 && hi < 500) begin @(posedge hclk); hi++; end
      while (lv(b) === 1'b0 && lo < 500) begin @(posedge hclk); lo++; end
   endtask : meas
   task automatic hold(input logic b, input logic e);
      int bad;
      bad = 0; repeat (100) @(posedge hclk); repeat (80) begin @(posedge hclk); if (lv(b) !== e) bad++; end
      `CHK(bad, 0)
   endtask : hold
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hwdata = '0;
      failures = 0; num_checks = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1; @(posedge hclk);
      xfer(1'b0, 32'h0000_0080, 0, v); `CHK(v, 32'h0000_0000)
      wr(32'h0000_0080, 32'h0000_00FF); xfer(1'b0, 32'h0000_0080, 0, v); `CHK(v, 32'h0000_00F3)
      xfer(1'b0, 32'h0000_0180, 0, v); `CHK(v, 32'h0000_0000)
      $display("test registers done");
      wr(32'h0000_0080, 0); wr(32'h0000_009C, 32'h0000_0031); repeat (4) @(posedge hclk);
      `CHK({ea, lvl_a, eb, lvl_b}, 4'b1100)
      wr(32'h0000_009C, 32'h0000_0003); wr(32'h0000_008C, 20); wr(32'h0000_0090, 5);
      wr(32'h0000_0080, 32'h0000_0061); wr(32'h0000_0084, 32'h0000_0011); // Mode 9, A toggles, B plain
      meas(1'b1); `CHK({hi, lo}, {32'd10, 32'd30})
      meas(1'b0); `CHK({hi, lo}, {32'd40, 32'd40})
      wr(32'h0000_0080, 32'h0000_0071); meas(1'b1); `CHK({hi, lo}, {32'd30, 32'd10})
      $display("test waveforms done");
      wr(32'h0000_0080, 32'h0000_0061); wr(32'h0000_0090, 0); hold(1'b1, 1'b0);
      wr(32'h0000_0090, 20); hold(1'b1, 1'b1);
      $display("test extremes done");
      wr(32'h0000_0084, 32'h0000_0010); xfer(1'b0, 32'h0000_0098, 0, v); `CHK(v, 32'h0000_0007)
      xfer(1'b0, 32'h0000_0088, 0, r); repeat (10) @(posedge hclk); xfer(1'b0, 32'h0000_0088, 0, v); `CHK(v, r)
      wr(32'h0000_0098, 32'h0000_000F); xfer(1'b0, 32'h0000_0098, 0, v); `CHK(v, 32'h0000_0000)
      $display("test flags done");
      // Fast PWM, capture as top 19, B field 2 with compare 5: high 6 of 20 cycles
      wr(32'h0000_0088, 0); wr(32'h0000_0094, 19); wr(32'h0000_0090, 5);
      wr(32'h0000_0080, 32'h0000_0022); wr(32'h0000_0084, 32'h0000_0019); // Mode 14, clock /1
      meas(1'b1); `CHK({hi, lo}, {32'd6, 32'd14})
      $display("test fast done");
      results();
   end
endmodule : tdp_timer_bench

// File: tdp_timer_sva.sv
// Checker for the timer's bus and pin ports.
// Assumes one hclk domain and a bind onto tdp_timer.
`timescale 1ns/1ps
module tdp_timer_sva
   import tdp_pkg::*;
(
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Pins
   input wire logic        pin_a_oe,
   input wire logic        pin_b_oe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic       rd_take;
   logic [3:0] dir_q_r;
   logic [3:0] dir_q_nxt;
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   // Recent direction writes; the pin enable may lag the bus by a few edges
   always_comb dir_q_nxt = {dir_q_r[2:0], hsel && htrans[1] && hready && hwrite && haddr == 32'h0000_009C};
   always_ff @(posedge hclk or negedge hresetn) if (!hresetn) dir_q_r <= '0; else dir_q_r <= dir_q_nxt;
   a_ready_high: assert property (hreadyout == 1'b1) else $error("ready dropped");
   a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
   a_rdata_idle: assert property (!rd_take |=> hrdata == 32'h0000_0000) else $error("stray read data");
   a_ctrl_layout: assert property (rd_take && haddr == 32'h0000_0080 |=> hrdata[31:8] == 24'h00_0000 && hrdata[3:2] == 2'b00) else $error("control bits wrong");
   a_upper_zero: assert property (rd_take |=> hrdata[31:16] == 16'h0000) else $error("upper bits set");
   a_unmapped_zero: assert property (rd_take && haddr[31:8] != 24'h00_0000 |=> hrdata == 32'h0000_0000) else $error("unmapped data");
   a_oe_a_cause: assert property ($changed(pin_a_oe) |-> |dir_q_r) else $error("enable A moved alone");
   a_oe_b_cause: assert property ($changed(pin_b_oe) |-> |dir_q_r) else $error("enable B moved alone");
   c_read: cover property (rd_take);
   c_oe_a: cover property ($rose(pin_a_oe));
   c_oe_b: cover property ($fell(pin_b_oe));
endmodule : tdp_timer_sva
bind tdp_timer tdp_timer_sva u_tdp_timer_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .pin_a_oe(pin_a_oe), .pin_b_oe(pin_b_oe));

// File: tdp_wave_chan.sv
// One compare-output channel: holds the waveform output bit.
// Assumes the caller supplies tick-qualified events and the match flags.
`timescale 1ns/1ps
module tdp_wave_chan
   import tdp_pkg::*;
(
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Timing events and channel setup
   input  wire tdp_evt_t   evt,
   input  wire logic [1:0] om,
   input  wire logic       toggle_ok,
   input  wire logic       match,
   input  wire logic       cmp_zero,
   input  wire logic       cmp_top,
   // Waveform output and pin connection
   output logic            wave,
   output logic            conn
);

   logic wave_r;
   logic wave_nxt;
   logic dual;

   assign dual = (evt.mode == MC_PCORR) || (evt.mode == MC_PFC);

   // Pin connection; value 1 only connects where toggling is allowed
   always_comb begin
      if (om == 2'b00) begin
         conn = 1'b0;
      end else if (om == 2'b01 && (evt.mode == MC_FAST || dual)) begin
         conn = toggle_ok;
      end else begin
         conn = 1'b1;
      end
   end

   // Next waveform value, evaluated only on a timer tick
   always_comb begin
      wave_nxt = wave_r;
      if (evt.tick && om != 2'b00) begin
         if (!dual && evt.mode != MC_FAST) begin
            if (match) begin
               unique case (om)
                  2'b01:   wave_nxt = ~wave_r;
                  2'b10:   wave_nxt = 1'b0;
                  default: wave_nxt = 1'b1;
               endcase
            end
         end else if (om == 2'b01) begin
            if (match && toggle_ok) begin
               wave_nxt = ~wave_r;
            end
         end else if (evt.mode == MC_FAST) begin
            // Match at top is ignored so the bottom action stands
            // Field 2 sets at bottom and clears on match; field 3 the reverse
            if (evt.at_bottom) begin
               wave_nxt = ~om[0];
            end else if (match && !cmp_top) begin
               wave_nxt = om[0];
            end
         end else begin
            // Extremes pin the level instead of relying on the match
            if (cmp_zero) begin
               wave_nxt = om[0];
            end else if (cmp_top) begin
               wave_nxt = ~om[0];
            end else if (match) begin
               wave_nxt = evt.up ? om[0] : ~om[0];
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wave_r <= 1'b0;
      end else begin
         wave_r <= wave_nxt;
      end
   end

   assign wave = wave_r;

endmodule : tdp_wave_chan
